// File: design/phase_lock_pkg.sv
// constants for the phase-lock supervisor and interrupt unit
package phase_lock_pkg;
    // register offsets on the serial configuration port
    localparam logic [6:0] ADDR_INT_ENABLE  = 7'h03;
    localparam logic [6:0] ADDR_INT_STATUS  = 7'h04;
    localparam logic [6:0] ADDR_PARAM_UPD   = 7'h24;
    localparam logic [6:0] ADDR_SEARCH_TOL  = 7'h2f;
    localparam logic [6:0] ADDR_ALIGN_CTRL  = 7'h33;
    localparam logic [6:0] ADDR_PHASE_DIR   = 7'h39;
    localparam logic [6:0] ADDR_DELAY_UPPER = 7'h3a;
    localparam logic [6:0] ADDR_CMP_BOOST   = 7'h3e;

    // interrupt status and enable bit positions
    localparam int ST_PARITY     = 7;
    localparam int ST_SATURATION = 6;
    localparam int ST_UPD_SET    = 5;
    localparam int ST_UPD_CLR    = 4;
    localparam int ST_LOCK_ACQ   = 3;
    localparam int ST_LOCK_DROP  = 2;
    localparam logic [7:0] STATUS_MASK = 8'hfc;

    // field positions
    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_SAMPLE  = 3;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_SLOPE   = 6;
    localparam int PD_DELAY_LSB = 7;
    localparam int PD_DIR_LO    = 5;
    localparam int TOL_EXACT    = 7;
    localparam int TOL_TRACK_RST = 5;
    localparam int PU_BIT       = 7;

    // reset values
    localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
    localparam logic [7:0] RST_INT_STATUS  = 8'h00;
    localparam logic [7:0] RST_PARAM_UPD   = 8'h00;
    localparam logic [7:0] RST_SEARCH_TOL  = 8'h00;
    localparam logic [7:0] RST_ALIGN_CTRL  = 8'h00;
    localparam logic [7:0] RST_PHASE_DIR   = 8'h00;
    localparam logic [7:0] RST_DELAY_UPPER = 8'h00;
    localparam logic [7:0] RST_CMP_BOOST   = 8'h08;

    // lock tracking limits
    localparam logic [4:0] LOCK_DROP_STEPS = 5'h05;
    localparam logic [4:0] LOOSE_WINDOW    = 5'h02;

    // serial frame: read flag, 7-bit address, 8 data bits
    localparam logic [4:0] SPI_INSTR_LAST = 5'h07;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
endpackage

// File: design/cfg_bus_if.sv
// register access carrier between serial port and register file
`timescale 1ns/10ps
interface cfg_bus_if;
    logic       wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// File: design/spi_config_port.sv
// serial configuration port slave, oversampled on the core clock
`timescale 1ns/10ps
module spi_config_port (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // serial pins
    input  wire logic cs_n_i,
    input  wire logic sclk_i,
    input  wire logic sdi_i,
    output logic      sdo_o,
    output logic      sdo_oe_o,
    // register side
    cfg_bus_if.port   bus
);
    logic       cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2;
    logic [4:0] bit_cnt;
    logic [6:0] shreg;
    logic [7:0] out_sh;
    logic       is_read;
    logic       load_rd;
    logic       rise, fall;

    // pins are asynchronous to clk_i: two stages before use
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            sdi_s1  <= 1'b0;
            sdi_s2  <= 1'b0;
        end else begin
            cs_s1   <= cs_n_i;
            cs_s2   <= cs_s1;
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sdi_s1  <= sdi_i;
            sdi_s2  <= sdi_s1;
        end
    end

    assign rise = sclk_s2 & ~sclk_s3 & ~cs_s2;
    assign fall = ~sclk_s2 & sclk_s3 & ~cs_s2;

    // frame shifter; bits past the sixteenth are ignored
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt    <= 5'h00;
            shreg      <= 7'h00;
            is_read    <= 1'b0;
            load_rd    <= 1'b0;
            bus.addr   <= 7'h00;
            bus.wdata  <= 8'h00;
            bus.wr_stb <= 1'b0;
        end else begin
            bus.wr_stb <= 1'b0;
            load_rd    <= 1'b0;
            if (cs_s2) begin
                bit_cnt <= 5'h00;
            end else if (rise) begin
                shreg <= {shreg[5:0], sdi_s2};
                if (bit_cnt != 5'h1f) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
                if (bit_cnt == phase_lock_pkg::SPI_INSTR_LAST) begin
                    is_read  <= shreg[6];
                    bus.addr <= {shreg[5:0], sdi_s2};
                    load_rd  <= shreg[6];
                end
                if (bit_cnt == phase_lock_pkg::SPI_FRAME_LAST && !is_read) begin
                    bus.wdata  <= {shreg, sdi_s2};
                    bus.wr_stb <= 1'b1;
                end
            end
        end
    end

    // read data leaves msb first; each fall presents the bit that the next rise takes,
    // so the fall right after the address must not skip bit 7
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_sh   <= 8'h00;
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else if (cs_s2) begin
            sdo_oe_o <= 1'b0;
            sdo_o    <= 1'b0;
        end else if (load_rd) begin
            out_sh   <= bus.rdata;
            sdo_o    <= bus.rdata[7];
            sdo_oe_o <= 1'b1;
        end else if (fall && sdo_oe_o) begin
            out_sh <= {out_sh[6:0], 1'b0};
            sdo_o  <= out_sh[7];
        end
    end

    a_write_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bus.wr_stb |=> !bus.wr_stb) else $error("write strobe longer than one cycle");
endmodule

// File: design/phase_lock_irq_startup.sv
// phase alignment supervisor: config registers, lock flags and interrupt unit
`timescale 1ns/10ps
// Operation
// - setting the control enable bit starts search then track.
// - after lock, status shows acquired set, dropped clear, phase reads 14.
// - only a rising sample bit refreshes readback; holding high does not.
// - parity and saturation faults raise interrupt events.
// - update bit set and clear each raise an event once registered.
// - dropped fires only after acquired was set; acquired fires on lock.
// - each interrupt source has its own enable bit.
// - status readable; single pin says only that something happened.
// - writing one to a status bit clears it.
// - acquired set and phase off by more than five: clear it, set dropped.
// - acquired is status bit 3, dropped is status bit 2.
// - after a sample edge, delay and phase fields read locked values.
module phase_lock_irq_startup (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    // serial configuration port
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    // alignment core measurements
    input  wire logic [4:0] meas_phase_i,
    input  wire logic [8:0] meas_delay_i,
    input  wire logic       phase_valid_i,
    // datapath fault events
    input  wire logic       parity_error_i,
    input  wire logic       saturation_error_i,
    // alignment core configuration
    output logic            align_enable_o,
    output logic [1:0]      align_mode_o,
    output logic            search_slope_o,
    output logic [1:0]      search_dir_o,
    output logic [4:0]      target_phase_o,
    output logic [8:0]      start_delay_o,
    output logic [4:0]      guard_band_o,
    output logic            search_exact_o,
    output logic            track_reset_o,
    output logic [7:0]      comparator_boost_o,
    output logic            param_update_o,
    // interrupt pin
    output logic            irq_o
);
    cfg_bus_if bus ();

    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_status_clear;
    logic [7:0] parameter_update;
    logic [7:0] search_tolerance_guard;
    logic [7:0] align_control;
    logic [7:0] search_phase_direction;
    logic [7:0] delay_upper;
    logic [7:0] comparator_boost;
    logic [7:0] next_status;
    logic [7:0] events;
    logic [7:0] clear_bits;
    logic       update_seen, update_reg;
    logic       locked, lock_hit, lock_fail;
    logic       lock_acquired, lock_dropped;
    logic       sample_q, sample_rise;
    logic [4:0] snap_phase;
    logic [8:0] snap_delay;
    logic [4:0] phase_dist;
    logic       show_locked;
    logic       irq;

    function automatic logic wr_to(input logic [6:0] a);
        return bus.wr_stb && (bus.addr == a);
    endfunction

    function automatic logic [4:0] phase_distance(input logic [4:0] a, input logic [4:0] b);
        return (a > b) ? 5'(a - b) : 5'(b - a);
    endfunction

    spi_config_port u_spi (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cs_n_i   (spi_cs_n_i),
        .sclk_i   (spi_sclk_i),
        .sdi_i    (spi_sdi_i),
        .sdo_o    (spi_sdo_o),
        .sdo_oe_o (spi_sdo_oe_o),
        .bus      (bus.port)
    );

    // plain configuration registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interrupt_enable       <= phase_lock_pkg::RST_INT_ENABLE;
            parameter_update       <= phase_lock_pkg::RST_PARAM_UPD;
            search_tolerance_guard <= phase_lock_pkg::RST_SEARCH_TOL;
            align_control          <= phase_lock_pkg::RST_ALIGN_CTRL;
            search_phase_direction <= phase_lock_pkg::RST_PHASE_DIR;
            delay_upper            <= phase_lock_pkg::RST_DELAY_UPPER;
            comparator_boost       <= phase_lock_pkg::RST_CMP_BOOST;
        end else begin
            if (wr_to(phase_lock_pkg::ADDR_INT_ENABLE)) begin
                interrupt_enable <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_PARAM_UPD)) begin
                parameter_update <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_SEARCH_TOL)) begin
                search_tolerance_guard <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_ALIGN_CTRL)) begin
                align_control <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_PHASE_DIR)) begin
                search_phase_direction <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_DELAY_UPPER)) begin
                delay_upper <= bus.wdata;
            end
            if (wr_to(phase_lock_pkg::ADDR_CMP_BOOST)) begin
                comparator_boost <= bus.wdata;
            end
        end
    end

    assign align_enable_o     = align_control[phase_lock_pkg::CTRL_ENABLE];
    assign align_mode_o       = align_control[phase_lock_pkg::CTRL_MODE_LO +: 2];
    assign search_slope_o     = align_control[phase_lock_pkg::CTRL_SLOPE];
    assign search_dir_o       = search_phase_direction[phase_lock_pkg::PD_DIR_LO +: 2];
    assign target_phase_o     = search_phase_direction[4:0];
    assign start_delay_o      = {delay_upper, search_phase_direction[phase_lock_pkg::PD_DELAY_LSB]};
    assign guard_band_o       = search_tolerance_guard[4:0];
    assign search_exact_o     = search_tolerance_guard[phase_lock_pkg::TOL_EXACT];
    assign track_reset_o      = search_tolerance_guard[phase_lock_pkg::TOL_TRACK_RST];
    assign comparator_boost_o = comparator_boost;
    assign param_update_o     = parameter_update[phase_lock_pkg::PU_BIT];

    // events come from the registered copy, not the raw write
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            update_reg  <= 1'b0;
            update_seen <= 1'b0;
        end else begin
            update_reg  <= parameter_update[phase_lock_pkg::PU_BIT];
            update_seen <= update_reg;
        end
    end

    // loose search accepts a phase within two codes of the target
    assign phase_dist = phase_distance(meas_phase_i, target_phase_o);
    assign lock_hit   = align_enable_o && phase_valid_i &&
                        (search_exact_o ? (phase_dist == 5'h00)
                                        : (phase_dist <= phase_lock_pkg::LOOSE_WINDOW));
    assign lock_fail  = locked && phase_valid_i && (phase_dist > phase_lock_pkg::LOCK_DROP_STEPS);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            locked <= 1'b0;
        end else if (!align_enable_o || lock_fail) begin
            locked <= 1'b0;
        end else if (lock_hit) begin
            locked <= 1'b1;
        end
    end

    // dropped only counts after acquired was flagged
    assign lock_acquired = lock_hit && !locked;
    assign lock_dropped  = lock_fail && interrupt_status_clear[phase_lock_pkg::ST_LOCK_ACQ];

    // fault and lock events into status
    always_comb begin
        events = 8'h00;
        events[phase_lock_pkg::ST_PARITY]     = parity_error_i;
        events[phase_lock_pkg::ST_SATURATION] = saturation_error_i;
        events[phase_lock_pkg::ST_UPD_SET]    = update_reg && !update_seen;
        events[phase_lock_pkg::ST_UPD_CLR]    = !update_reg && update_seen;
        events[phase_lock_pkg::ST_LOCK_ACQ]   = lock_acquired;
        events[phase_lock_pkg::ST_LOCK_DROP]  = lock_dropped;
    end

    // write one clears; a same-cycle event still wins
    always_comb begin
        clear_bits  = wr_to(phase_lock_pkg::ADDR_INT_STATUS) ? bus.wdata : 8'h00;
        next_status = ((interrupt_status_clear & ~clear_bits) | events)
                      & phase_lock_pkg::STATUS_MASK;
        // losing lock withdraws the acquired flag
        if (lock_dropped) begin
            next_status[phase_lock_pkg::ST_LOCK_ACQ] = 1'b0;
        end
    end

    // status bit layout, acquired 3 and dropped 2
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interrupt_status_clear <= phase_lock_pkg::RST_INT_STATUS;
        end else begin
            interrupt_status_clear <= next_status;
        end
    end

    // one pin for all sources, registered for a clean edge
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq <= 1'b0;
        end else begin
            irq <= |(interrupt_status_clear & interrupt_enable);
        end
    end

    assign irq_o = irq;

    // capture only on the rising sample bit
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= align_control[phase_lock_pkg::CTRL_SAMPLE];
        end
    end

    assign sample_rise = align_control[phase_lock_pkg::CTRL_SAMPLE] && !sample_q;

    // snapshot of the locked delay and phase
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_phase  <= 5'h00;
            snap_delay  <= 9'h000;
            show_locked <= 1'b0;
        end else if (sample_rise) begin
            snap_phase  <= meas_phase_i;
            snap_delay  <= meas_delay_i;
            show_locked <= 1'b1;
        end else if (wr_to(phase_lock_pkg::ADDR_PHASE_DIR) ||
                     wr_to(phase_lock_pkg::ADDR_DELAY_UPPER)) begin
            show_locked <= 1'b0;
        end
    end

    // readback of status and locked phase
    always_comb begin
        unique case (bus.addr)
            phase_lock_pkg::ADDR_INT_ENABLE:  bus.rdata = interrupt_enable;
            phase_lock_pkg::ADDR_INT_STATUS:  bus.rdata = interrupt_status_clear;
            phase_lock_pkg::ADDR_PARAM_UPD:   bus.rdata = parameter_update;
            phase_lock_pkg::ADDR_SEARCH_TOL:  bus.rdata = search_tolerance_guard;
            phase_lock_pkg::ADDR_ALIGN_CTRL:  bus.rdata = align_control;
            phase_lock_pkg::ADDR_PHASE_DIR:   bus.rdata = show_locked ?
                {snap_delay[0], search_dir_o, snap_phase} : search_phase_direction;
            phase_lock_pkg::ADDR_DELAY_UPPER: bus.rdata = show_locked ?
                snap_delay[8:1] : delay_upper;
            phase_lock_pkg::ADDR_CMP_BOOST:   bus.rdata = comparator_boost;
            default:                          bus.rdata = 8'h00;
        endcase
    end

    // checks
    a_enable_starts: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_to(phase_lock_pkg::ADDR_ALIGN_CTRL) && bus.wdata[0]) |=> align_enable_o)
        else $error("enable write did not start controller");
    a_acq_sets: assert property (@(posedge clk_i) disable iff (!resetn_i)
        lock_acquired |=> interrupt_status_clear[3]) else $error("lock acquired not flagged");
    a_drop_needs_acq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(interrupt_status_clear[2]) |-> $past(interrupt_status_clear[3]))
        else $error("lock dropped without prior acquired");
    a_drop_clears_acq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        lock_dropped |=> !interrupt_status_clear[3] && interrupt_status_clear[2])
        else $error("lock loss not reflected in status");
    a_w1c_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_to(phase_lock_pkg::ADDR_INT_STATUS) && bus.wdata[2] && !lock_dropped)
        |=> !interrupt_status_clear[2]) else $error("write one did not clear status");
    a_parity_evt: assert property (@(posedge clk_i) disable iff (!resetn_i)
        parity_error_i |=> interrupt_status_clear[7]) else $error("parity fault lost");
    a_sat_evt: assert property (@(posedge clk_i) disable iff (!resetn_i)
        saturation_error_i |=> interrupt_status_clear[6]) else $error("saturation fault lost");
    a_upd_set_evt: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(update_reg) |=> interrupt_status_clear[5]) else $error("update set event lost");
    a_upd_clr_evt: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(update_reg) |=> interrupt_status_clear[4]) else $error("update clear event lost");
    a_irq_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (|(interrupt_status_clear & interrupt_enable)) |=> irq_o)
        else $error("interrupt pin missed enabled status");
    a_irq_masked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(|(interrupt_status_clear & interrupt_enable)) |=> !irq_o)
        else $error("interrupt pin high with nothing enabled");
    a_sample_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (align_control[3] && sample_q) |=> $stable(snap_phase) && $stable(snap_delay))
        else $error("readback refreshed while sample held high");
    a_sample_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sample_rise |=> show_locked && snap_phase == $past(meas_phase_i))
        else $error("sample edge did not capture phase");
endmodule

// File: dv/cfg_host_model.sv
// serial host model driving the configuration port
`timescale 1ns/10ps
module cfg_host_model (
    // clock
    input  wire logic clk_i,
    // serial pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end
    // half period of ten core clocks keeps the oversampler comfortable
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, a, wd};
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_o = frame[i];
            repeat (10) @(negedge clk_i);
            sclk_o = 1'b1;
            if (i < 8) rdata[i] = sdo_i;
            repeat (10) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        cs_n_o = 1'b1;
        // released data line must not hold its last bit
        sdi_o = ~sdi_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// File: dv/phase_lock_irq_startup_tb.sv
// self-checking bench for the phase-lock supervisor
`timescale 1ns/10ps
module phase_lock_irq_startup_tb;
    localparam logic [6:0] EN = phase_lock_pkg::ADDR_INT_ENABLE;
    localparam logic [6:0] STS = phase_lock_pkg::ADDR_INT_STATUS;
    localparam logic [6:0] PU = phase_lock_pkg::ADDR_PARAM_UPD;
    localparam logic [6:0] CTL = phase_lock_pkg::ADDR_ALIGN_CTRL;
    localparam logic [6:0] PD = phase_lock_pkg::ADDR_PHASE_DIR;
    localparam logic [6:0] DU = phase_lock_pkg::ADDR_DELAY_UPPER;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       cs_n, sclk, sdi, sdo, align_en, exact, slope, irq;
    logic       sdo_oe, track_rst, pupd;
    logic [1:0] mode, dir;
    logic [7:0] boost;
    logic       vld = 1'b0;
    logic       par_err = 1'b0;
    logic       sat_err = 1'b0;
    logic [4:0] meas_phase = 5'h00;
    logic [4:0] tgt, guard;
    logic [8:0] meas_delay = 9'h000;
    logic [8:0] start;
    int         num_errors = 0;
    int         n_checks = 0;
    always #10 clk_i = ~clk_i;
    cfg_host_model i_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));
    phase_lock_irq_startup i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .spi_cs_n_i(cs_n),
        .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .meas_phase_i(meas_phase), .meas_delay_i(meas_delay), .phase_valid_i(vld),
        .parity_error_i(par_err), .saturation_error_i(sat_err), .align_enable_o(align_en),
        .align_mode_o(mode), .search_slope_o(slope), .search_dir_o(dir), .target_phase_o(tgt),
        .start_delay_o(start), .guard_band_o(guard), .search_exact_o(exact),
        .track_reset_o(track_rst), .comparator_boost_o(boost), .param_update_o(pupd),
        .irq_o(irq));
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_host.xfer(1'b0, a, d, unused);
    endtask
    task automatic rd(input string name, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_host.xfer(1'b1, a, 8'h00, v);
        check(name, {1'b0, v}, {1'b0, exp});
    endtask
    task automatic setup_search();
        rd("boost reset", phase_lock_pkg::ADDR_CMP_BOOST, 8'h08);
        rd("unmapped", 7'h10, 8'h00);
        wr(phase_lock_pkg::ADDR_CMP_BOOST, 8'h38);
        check("boost", {1'b0, boost}, 9'h038);
        wr(PU, 8'h00);
        wr(PU, 8'h80);
        check("update bit", {8'h00, pupd}, 9'h001);
        rd("update set", STS, 8'h20);
        wr(phase_lock_pkg::ADDR_SEARCH_TOL, 8'hce);
        wr(CTL, 8'h42);
        wr(PD, 8'h4e);
        wr(DU, 8'h6c);
        check("guard", {4'h0, guard}, 9'h00e);
        check("target", {4'h0, tgt}, 9'h00e);
        check("start", start, 9'h0d8);
        check("mode bits", {6'h00, align_en, exact, slope}, 9'h003);
        check("dir mode track", {4'h0, dir, mode, track_rst}, 9'h010);
        check("oe idle", {8'h00, sdo_oe}, 9'h000);
    endtask
    task automatic lock_and_sample();
        wr(EN, 8'h00);
        wr(STS, 8'hfe);
        rd("cleared", STS, 8'h00);
        wr(EN, 8'h0c);
        wr(CTL, 8'h43);
        check("started", {8'h00, align_en}, 9'h001);
        meas_delay = 9'h0d7;
        meas_phase = 5'h0e;
        vld = 1'b1;
        repeat (3) @(negedge clk_i);
        check("irq on lock", {8'h00, irq}, 9'h001);
        wr(CTL, 8'h4b);
        wr(CTL, 8'h43);
        rd("lock status", STS, 8'h08);
        rd("phase back", PD, 8'hce);
        rd("delay back", DU, 8'h6b);
    endtask
    task automatic hold_sample();
        wr(CTL, 8'h4b);
        meas_delay = 9'h0d9;
        rd("held", DU, 8'h6b);
        wr(CTL, 8'h43);
        wr(CTL, 8'h4b);
        rd("resampled", DU, 8'h6c);
        wr(PD, 8'hce);
        wr(DU, 8'h6b);
        check("manual code", start, 9'h0d7);
    endtask
    task automatic lose_lock();
        meas_phase = 5'h13;
        rd("five off", STS, 8'h08);
        meas_phase = 5'h14;
        repeat (3) @(negedge clk_i);
        vld = 1'b0;
        rd("dropped", STS, 8'h04);
        check("irq drop", {8'h00, irq}, 9'h001);
        wr(STS, 8'h04);
        repeat (3) @(negedge clk_i);
        check("irq clear", {8'h00, irq}, 9'h000);
    endtask
    task automatic faults();
        par_err = 1'b1;
        @(negedge clk_i);
        par_err = 1'b0;
        sat_err = 1'b1;
        @(negedge clk_i);
        sat_err = 1'b0;
        wr(PU, 8'h00);
        check("masked", {8'h00, irq}, 9'h000);
        rd("fault status", STS, 8'hd0);
        wr(PU, 8'h80);
        wr(EN, 8'h40);
        repeat (3) @(negedge clk_i);
        check("sat enabled", {8'h00, irq}, 9'h001);
        // loose search takes a phase two codes off target
        wr(phase_lock_pkg::ADDR_SEARCH_TOL, 8'h4e);
        meas_phase = 5'h10;
        vld = 1'b1;
        rd("loose lock", STS, 8'hf8);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        setup_search();
        lock_and_sample();
        hold_sample();
        lose_lock();
        faults();
        wrap_up();
    end
    // hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
endmodule
